// [squib_cmd_pkg.sv]
// package: constants and carrier types for the squib serial command decoder
`default_nettype none
package squib_cmd_pkg;
  // ---------------------------------------------------------------
  // word layout
  // ---------------------------------------------------------------
  localparam int          WORD_BITS   = 16;
  localparam int          PARITY_BIT  = 13;
  localparam int          RW_BIT      = 12;
  localparam int          SWR_BIT     = 11;
  localparam int          CFG_SEL_BIT = 10;
  localparam logic [15:0] RESP_ZERO   = 16'h0000;
  localparam logic [15:0] RESP_PARITY = 16'hD000;
  localparam logic [15:0] RESP_COUNT  = 16'hD003;
  localparam logic [15:0] RESP_SEQ    = 16'hD005;
  localparam logic [15:0] RESP_BUSY   = 16'hD009;
  localparam logic [15:0] RESP_SWR2   = 16'h2003;
  localparam logic [15:0] RESP_SWR1   = 16'h1802; // d11 set, d10 clear, d9:d8 or'ed in
  localparam logic [15:0] RESP_CFG1   = 16'h0002; // low byte of config mode 1 answer
  localparam logic [7:0]  SWR_KEY1    = 8'hAA;
  localparam logic [7:0]  SWR_KEY2    = 8'h55;
  localparam logic [4:0]  ARM_CODE    = 5'h19;
  localparam logic [4:0]  FIRE_CODE   = 5'h00;
  localparam logic [1:0]  CL_DEFAULT  = 2'h0;
  localparam logic [1:0]  LVL_LOW     = 2'h0;
  localparam logic [1:0]  LVL_MID     = 2'h1;
  localparam logic [1:0]  LVL_HIGH    = 2'h3;
  localparam logic [2:0]  DIAG_SUPPLY = 3'h2;
  localparam logic [2:0]  DIAG_SAFING = 3'h3;
  localparam logic [2:0]  DIAG_LS     = 3'h6;
  localparam logic [3:0]  CNT_ZERO    = 4'h0;

  // command classes from the two top bits
  typedef enum logic [1:0] {
    CLS_CONFIG  = 2'b00,
    CLS_DEPLOY  = 2'b01,
    CLS_DIAG    = 2'b10,
    CLS_MONITOR = 2'b11
  } cmd_class_t;

  // one received frame as handed to the core clock domain
  typedef struct packed {
    logic [15:0] word;
    logic        count_ok;
  } frame_t;

  // analog comparator levels feeding the diagnostics
  typedef struct packed {
    logic safing_above_short;
    logic safing_above_open;
    logic supply_above_low;
    logic supply_above_high;
  } comp_t;
endpackage : squib_cmd_pkg
`default_nettype wire

// [squib_spi_command_decoder.sv]
// squib serial port command decoder and response generator
//
// Functional notes
// - safing diagnostic enables test current, returns 00, 01 or 11 result.
// - supply diagnostic returns 00, 01 or 11 level code.
// - both diagnostics sample comparators at next chip-select fall, report next frame.
// - lost channel ground keeps its low-side driver off; rest works.
// - lost ground shows as a 0x0000 reply, not in the low-side driver diagnostic.
// - every command and response word except 0x0000 has odd parity via bit 13.
// - response to a command goes out in the next valid frame.
// - first frame after reset or ground loss returns 0x0000.
// - parity error or message error during deployment returns 0xD000.
// - wrong clock or bit count returns 0xD003 next frame.
// - fire without valid arm flags sequence error, returns 0xD005.
// - command not allowed during deployment returns 0xD009.
// - reference resistor out of range returns 0x0000 next frame.
// - first soft-reset byte answers 0x1802 with stored current select in bits 9:8, parity in bit 13.
// - second soft-reset byte after the first answers 0x2003.
// - two top bits pick configuration, deployment, diagnostic or monitor class.
// - deployment bits 12..8 11001 arm, 00000 fire.
// - configuration bit 10 chooses current/soft reset or latch-time programming.
// - diagnostic bits 11..9 select one of eight diagnostics.
// - monitor bits 11..10 are echoed; reply carries monitor_data[9:0].
// - parity checks integrity; fault codes refer to preceding frame.
// - soft reset resets squib and satellite circuits.
// - soft reset only after 0xAA then 0x55 in consecutive frames.
`default_nettype none
module squib_spi_command_decoder #(
  parameter int CHANNELS = 8
) (
  // core clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // squib serial port, link clock domain (mode 0 style, sample on rise)
  input  wire logic                   sclk,
  input  wire logic                   cs_low,
  input  wire logic                   mosi,
  output logic                        miso,
  // analog and pin status, asynchronous
  input  wire logic                   reset_pin_low,
  input  wire logic [CHANNELS-1:0]    channel_power_ground,
  input  wire logic                   reference_resistor,
  input  wire squib_cmd_pkg::comp_t   comp_in,
  // status inputs from deployment logic (same clock)
  input  wire logic                   deploy_active,
  input  wire logic                   ls_diag_fault,
  input  wire logic [15:0]            monitor_data,
  // control outputs
  output logic [2:0]                  diag_select,
  output logic [2:0]                  diag_channel,
  output logic                        safing_test_current,
  output logic [1:0]                  firing_current_select,
  output logic [1:0]                  fire_latch_time,
  output logic                        arm_pulse,
  output logic                        fire_pulse,
  output logic [CHANNELS-1:0]         low_side_enable,
  output logic                        soft_reset
);

  // ---------------------------------------------------------------
  // link domain: shift in, count bits, shift out
  // ---------------------------------------------------------------
  logic [15:0] rx_sh_r;
  logic [4:0]  rx_cnt_r;
  logic [4:0]  tx_cnt_r;
  logic        rx_tog_r;
  squib_cmd_pkg::frame_t rx_frame_r;
  logic [15:0] resp_word_r;          // core domain, stable while cs is low
  logic        tx_tog_r;             // core domain toggle, declared but never driven or read

  // receive on rising sclk; counter and shifter reset by the frame itself
  always_ff @(posedge sclk or posedge cs_low) begin
    if (cs_low) begin
      rx_cnt_r <= 5'h00;
      rx_sh_r  <= 16'h0000;
    end else begin
      rx_sh_r  <= {rx_sh_r[14:0], mosi};
      if (rx_cnt_r != 5'h1F) rx_cnt_r <= rx_cnt_r + 5'h01;
    end
  end

  // capture the frame on cs rise; toggle announces it to the core
  always_ff @(posedge cs_low or posedge rst) begin
    if (rst) begin
      rx_frame_r <= '0;
      rx_tog_r   <= 1'b0;
    end else begin
      rx_frame_r.word     <= rx_sh_r;
      rx_frame_r.count_ok <= (rx_cnt_r == 5'(squib_cmd_pkg::WORD_BITS));
      rx_tog_r            <= ~rx_tog_r;
    end
  end

  // transmit: count falling sclk edges, pick the reply bit msb first
  // reply word only moves while cs is high, so no link-side copy is needed
  // limitation: a ground loss or pin reset inside a frame can tear that frame
  always_ff @(negedge sclk or posedge cs_low) begin
    if (cs_low)                 tx_cnt_r <= 5'h00;
    else if (tx_cnt_r != 5'h1F) tx_cnt_r <= tx_cnt_r + 5'h01;
  end
  assign miso = (cs_low || tx_cnt_r[4]) ? 1'b0
                                        : resp_word_r[4'hF - tx_cnt_r[3:0]];

  // ---------------------------------------------------------------
  // core domain synchronisers
  // ---------------------------------------------------------------
  logic [2:0] tog_s_r;
  logic [2:0] cs_s_r;
  logic [1:0] rpin_s_r;
  logic [1:0] rref_s_r;
  logic [CHANNELS-1:0] gnd_s1_r, gnd_s2_r;
  squib_cmd_pkg::comp_t comp_s1_r, comp_s2_r;

  always_ff @(posedge clk) begin
    tog_s_r   <= {tog_s_r[1:0], rx_tog_r};
    cs_s_r    <= {cs_s_r[1:0], cs_low};
    rpin_s_r  <= {rpin_s_r[0], reset_pin_low};
    rref_s_r  <= {rref_s_r[0], reference_resistor};
    gnd_s1_r  <= channel_power_ground;
    gnd_s2_r  <= gnd_s1_r;
    comp_s1_r <= comp_in;
    comp_s2_r <= comp_s1_r;
  end

  wire frame_done = tog_s_r[2] ^ tog_s_r[1];

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] with_parity(input logic [15:0] w);
    logic [15:0] t;
    t = w;
    t[squib_cmd_pkg::PARITY_BIT] = 1'b0;
    t[squib_cmd_pkg::PARITY_BIT] = ~^t;
    return t;
  endfunction : with_parity

  function automatic logic [1:0] level_code(input logic above_lo, input logic above_hi);
    if (above_hi)      return squib_cmd_pkg::LVL_HIGH;
    else if (above_lo) return squib_cmd_pkg::LVL_MID;
    else               return squib_cmd_pkg::LVL_LOW;
  endfunction : level_code

  // ---------------------------------------------------------------
  // core state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DG_IDLE    = 2'b00,
    DG_WAIT_CS = 2'b01,
    DG_DONE    = 2'b10
  } dg_state_t;

  typedef struct packed {
    logic [15:0] resp;
    logic        first;
    logic        armed;
    logic        swr_half;
    logic [1:0]  cl;
    logic [1:0]  latch;
    logic [2:0]  dsel;
    logic [2:0]  dch;
    dg_state_t   dg;
    logic [1:0]  result;
    logic        arm_p;
    logic        fire_p;
    logic        swr_p;
    logic        rpin_d;
    logic [CHANNELS-1:0] gnd_d;
  } state_t;

  state_t s_r, s_nxt;
  assign resp_word_r = s_r.resp;

  logic [15:0]            w;
  squib_cmd_pkg::cmd_class_t cls;
  logic                   cs_fall_c;
  logic                   ground_lost_c;
  logic                   par_ok;

  assign w         = rx_frame_r.word;   // stable: changed only at cs rise, seen after sync
  assign cls       = squib_cmd_pkg::cmd_class_t'(w[15:14]);
  assign par_ok    = ^w;
  assign cs_fall_c = cs_s_r[2] & ~cs_s_r[1];   // edge taken past the second flop only
  assign ground_lost_c = |(~gnd_s2_r & s_r.gnd_d);

  // single next-state process
  always_comb begin
    s_nxt        = s_r;
    s_nxt.arm_p  = 1'b0;
    s_nxt.fire_p = 1'b0;
    s_nxt.swr_p  = 1'b0;
    s_nxt.rpin_d = rpin_s_r[1];
    s_nxt.gnd_d  = gnd_s2_r;
    // comparators sampled at the chip-select fall after the command
    if (s_r.dg == DG_WAIT_CS && cs_fall_c) begin
      s_nxt.dg = DG_DONE;
      if (s_r.dsel == squib_cmd_pkg::DIAG_SAFING)
        s_nxt.result = level_code(comp_s2_r.safing_above_short,
                                  comp_s2_r.safing_above_open);
      else
        s_nxt.result = level_code(comp_s2_r.supply_above_low,
                                  comp_s2_r.supply_above_high);
    end
    if (frame_done) begin
      s_nxt.first = 1'b0;
      if (!rx_frame_r.count_ok) begin
        s_nxt.resp     = squib_cmd_pkg::RESP_COUNT;
        s_nxt.swr_half = 1'b0;
      end else if (!par_ok) begin
        s_nxt.resp     = squib_cmd_pkg::RESP_PARITY;
        s_nxt.swr_half = 1'b0;
      end else if (deploy_active && cls != squib_cmd_pkg::CLS_MONITOR) begin
        s_nxt.resp     = squib_cmd_pkg::RESP_BUSY;
        s_nxt.swr_half = 1'b0;
      end else begin
        s_nxt.resp     = with_parity(w);
        s_nxt.swr_half = 1'b0;
        case (cls)
          squib_cmd_pkg::CLS_CONFIG: begin
            if (w[squib_cmd_pkg::CFG_SEL_BIT]) begin
              if (w[squib_cmd_pkg::RW_BIT]) s_nxt.latch = w[9:8];
              s_nxt.resp = with_parity({w[15:14], 1'b0, w[12], 2'b01, s_nxt.latch, 8'h00});
            end else if (w[squib_cmd_pkg::RW_BIT] && w[squib_cmd_pkg::SWR_BIT]) begin
              if (s_r.swr_half && w[7:0] == squib_cmd_pkg::SWR_KEY2) begin
                s_nxt.resp  = with_parity(squib_cmd_pkg::RESP_SWR2);
                s_nxt.swr_p = 1'b1;
              end else if (w[7:0] == squib_cmd_pkg::SWR_KEY1) begin
                s_nxt.swr_half = 1'b1;
                s_nxt.resp = with_parity(squib_cmd_pkg::RESP_SWR1 |
                                         {6'h00, s_r.cl, 8'h00});
              end else begin
                s_nxt.resp = with_parity({w[15:8], squib_cmd_pkg::RESP_CFG1[7:0]});
              end
            end else begin
              if (w[squib_cmd_pkg::RW_BIT]) s_nxt.cl = w[9:8];
              s_nxt.resp = with_parity({w[15:14], 1'b0, w[12:10], s_nxt.cl,
                                        squib_cmd_pkg::RESP_CFG1[7:0]});
            end
          end
          squib_cmd_pkg::CLS_DEPLOY: begin
            if (w[12:8] == squib_cmd_pkg::ARM_CODE) begin
              s_nxt.armed = 1'b1;
              s_nxt.arm_p = 1'b1;
            end else if (w[12:8] == squib_cmd_pkg::FIRE_CODE) begin
              if (s_r.armed) s_nxt.fire_p = 1'b1;
              else           s_nxt.resp   = squib_cmd_pkg::RESP_SEQ;
              s_nxt.armed = 1'b0;
            end
          end
          squib_cmd_pkg::CLS_DIAG: begin
            s_nxt.dsel = w[11:9];
            s_nxt.dch  = w[2:0];
            s_nxt.dg   = (w[11:9] == squib_cmd_pkg::DIAG_SUPPLY ||
                          w[11:9] == squib_cmd_pkg::DIAG_SAFING) ? DG_WAIT_CS : DG_IDLE;
            if (s_r.dg == DG_DONE)
              s_nxt.resp = with_parity({w[15:14], 1'b0, w[12:2], s_r.result});
            else if (s_r.dsel == squib_cmd_pkg::DIAG_LS && ls_diag_fault)
              s_nxt.resp = with_parity({w[15:14], 1'b0, w[12:2], 2'b01});
          end
          squib_cmd_pkg::CLS_MONITOR: begin
            s_nxt.resp = with_parity({w[15:14], 1'b0, w[12:10], monitor_data[9:0]});
          end
          default: s_nxt.resp = squib_cmd_pkg::RESP_ZERO;
        endcase
      end
      if (!rref_s_r[1]) s_nxt.resp = squib_cmd_pkg::RESP_ZERO;
    end
    // first frame after reset pin release or ground loss answers zero
    if ((rpin_s_r[1] && !s_r.rpin_d) || ground_lost_c) begin
      s_nxt.first = 1'b1;
      s_nxt.resp  = squib_cmd_pkg::RESP_ZERO;
    end
    if (s_r.first && !frame_done) s_nxt.resp = squib_cmd_pkg::RESP_ZERO;
  end

  // register the state; soft reset or pin acts like power-on, soft reset keeps the answer, pin zeroes it
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r       <= '0;
      s_r.first <= 1'b1;
      s_r.cl    <= squib_cmd_pkg::CL_DEFAULT;
      s_r.resp  <= squib_cmd_pkg::RESP_ZERO;
      s_r.gnd_d <= '1;
      s_r.rpin_d <= 1'b1;
    end else if (s_r.swr_p || !rpin_s_r[1]) begin
      s_r        <= '0;
      s_r.resp   <= rpin_s_r[1] ? s_r.resp : squib_cmd_pkg::RESP_ZERO;
      s_r.first  <= !rpin_s_r[1];
      s_r.gnd_d  <= gnd_s2_r;
      s_r.rpin_d <= rpin_s_r[1];
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign diag_select           = s_r.dsel;
  assign diag_channel          = s_r.dch;
  assign safing_test_current   = (s_r.dsel == squib_cmd_pkg::DIAG_SAFING) &&
                                 (s_r.dg != DG_IDLE);
  assign firing_current_select = s_r.cl;
  assign fire_latch_time       = s_r.latch;
  assign arm_pulse             = s_r.arm_p;
  assign fire_pulse            = s_r.fire_p;
  assign low_side_enable       = {CHANNELS{s_r.fire_p}} & gnd_s2_r;
  assign soft_reset            = s_r.swr_p;
endmodule : squib_spi_command_decoder
`default_nettype wire

// [squib_cmd_properties.sv]
// checker: timing relations at the ports of the squib command decoder
`default_nettype none
module squib_cmd_properties #(
  parameter int CHANNELS = 8
) (
  // core clock domain
  input wire logic                clk,
  input wire logic                rst,
  // serial port
  input wire logic                cs_low,
  input wire logic                miso,
  // status inputs
  input wire logic [CHANNELS-1:0] channel_power_ground,
  input wire logic                deploy_active,
  // control outputs
  input wire logic [2:0]          diag_select,
  input wire logic                safing_test_current,
  input wire logic [1:0]          firing_current_select,
  input wire logic                arm_pulse,
  input wire logic                fire_pulse,
  input wire logic [CHANNELS-1:0] low_side_enable,
  input wire logic                soft_reset
);
  // ---------------------------------------------------------------
  // shared clocking and sequences
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // a pulse is gone on the following edge
  sequence s_gone(logic p);
    ##1 !p;
  endsequence
  // frame closed for two samples, so async cs edges cannot race miso
  sequence s_cs_idle;
    cs_low [*2];
  endsequence
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_arm_single: assert property (arm_pulse |-> s_gone(arm_pulse))
    else $error("arm pulse longer than one cycle");
  a_fire_single: assert property (fire_pulse |-> s_gone(fire_pulse))
    else $error("fire pulse longer than one cycle");
  a_swr_single: assert property (soft_reset |-> s_gone(soft_reset))
    else $error("soft reset longer than one cycle");
  a_arm_fire_excl: assert property (!(arm_pulse && fire_pulse))
    else $error("arm and fire together");
  a_ls_ground: assert property (fire_pulse && $stable(channel_power_ground) &&
    $past(channel_power_ground, 2) == channel_power_ground
    |-> low_side_enable == channel_power_ground)
    else $error("low side enable not gated by ground");
  a_ls_idle: assert property (!fire_pulse |-> low_side_enable == '0)
    else $error("low side on without fire");
  a_exec_closed: assert property ((arm_pulse || fire_pulse || soft_reset) |-> cs_low)
    else $error("command executed inside a frame");
  a_safing_sel: assert property (safing_test_current
    |-> diag_select == squib_cmd_pkg::DIAG_SAFING)
    else $error("test current without safing diagnostic");
  a_swr_clear: assert property (soft_reset
    |-> ##[0:2] firing_current_select == squib_cmd_pkg::CL_DEFAULT)
    else $error("soft reset kept current select");
  a_busy_hold: assert property (deploy_active [*5] |-> !arm_pulse && !fire_pulse)
    else $error("deployment command run while busy");
  a_miso_idle: assert property (s_cs_idle |-> !miso)
    else $error("miso driven outside a frame");
endmodule : squib_cmd_properties
bind squib_spi_command_decoder squib_cmd_properties #(.CHANNELS(CHANNELS)) props (
  .clk(clk), .rst(rst), .cs_low(cs_low), .miso(miso),
  .channel_power_ground(channel_power_ground), .deploy_active(deploy_active),
  .diag_select(diag_select), .safing_test_current(safing_test_current),
  .firing_current_select(firing_current_select), .arm_pulse(arm_pulse),
  .fire_pulse(fire_pulse), .low_side_enable(low_side_enable), .soft_reset(soft_reset));
`default_nettype wire

// [squib_host_model.sv]
// host model: serial master framing words for the squib command port
`default_nettype none
module squib_host_model (
  // serial lines toward the device
  output logic      sclk,
  output logic      cs_low,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle: clock parked low, frame closed
  initial begin
    sclk = 1'b0;
    cs_low = 1'b1;
    mosi = 1'b0;
  end
  // one frame of n bits, msb first; sclk runs only inside the frame
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    cs_low = 1'b0;
    #20;
    for (int i = 15; i > 15 - n; i--) begin
      mosi = w[i];
      #15;
      sclk = 1'b1;
      r = {r[14:0], miso};
      #15;
      sclk = 1'b0;
    end
    #20;
    cs_low = 1'b1;
    mosi = ~mosi; // released line must not show its last bit
    #400; // gap of eight core clocks, above the six the port needs
  endtask : xfer
endmodule : squib_host_model
`default_nettype wire

// [tb_top.sv]
// testbench: drives the squib command decoder through the host model
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 sclk, cs_low, mosi, miso, safing_test_current;
  logic                 reset_pin_low = 1'b1;
  logic                 reference_resistor = 1'b1;
  logic                 deploy_active = 1'b0;
  logic                 ls_fault = 1'b0;
  logic [7:0]           ground = 8'hFF;
  logic [15:0]          monitor_data = 16'h0155;
  squib_cmd_pkg::comp_t comp = '0;
  logic [2:0]           diag_select, diag_channel;
  logic                 arm_pulse, fire_pulse, soft_reset;
  logic [1:0]           firing_current_select, fire_latch_time;
  logic [7:0]           low_side_enable, ls_seen = 8'h00;
  logic [15:0]          arm_seen = 16'h0000, fire_seen = 16'h0000, swr_seen = 16'h0000;
  int                   err_count = 0, check_count = 0, cycles = 0;
  always #25 clk = ~clk;
  squib_host_model host (.sclk(sclk), .cs_low(cs_low), .mosi(mosi), .miso(miso));
  squib_spi_command_decoder #(.CHANNELS(8)) dut (.clk(clk), .rst(rst), .sclk(sclk),
    .cs_low(cs_low), .mosi(mosi), .miso(miso), .reset_pin_low(reset_pin_low),
    .channel_power_ground(ground), .reference_resistor(reference_resistor), .comp_in(comp),
    .deploy_active(deploy_active), .ls_diag_fault(ls_fault), .monitor_data(monitor_data),
    .diag_select(diag_select), .diag_channel(diag_channel),
    .safing_test_current(safing_test_current), .firing_current_select(firing_current_select),
    .fire_latch_time(fire_latch_time), .arm_pulse(arm_pulse), .fire_pulse(fire_pulse),
    .low_side_enable(low_side_enable), .soft_reset(soft_reset));
  // pulse tally; one-cycle pulses are easy to miss from the tasks
  always @(posedge clk) begin
    if (arm_pulse === 1'b1) arm_seen <= arm_seen + 16'h0001;
    if (fire_pulse === 1'b1) fire_seen <= fire_seen + 16'h0001;
    if (fire_pulse === 1'b1) ls_seen <= low_side_enable;
    if (soft_reset === 1'b1) swr_seen <= swr_seen + 16'h0001;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] par(input logic [15:0] w);
    logic [15:0] v;
    v = w & 16'hDFFF;
    v[13] = ~^v;
    return v;
  endfunction : par
  task automatic tick;
    @(posedge clk);
    #2;
  endtask : tick
  task automatic send(input logic [15:0] w, input int n, input logic flip,
                      output logic [15:0] r);
    host.xfer(par(w) ^ {2'b00, flip, 13'h0000}, n, r);
  endtask : send
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_deploy;
    logic [15:0] r;
    send(16'hC000, 16, 1'b0, r);
    chk("first reply", 16'h0000, r);
    tick();
    ground = 8'hF7; // channel 3 ground lost for the rest of the run
    send(16'h5900, 16, 1'b0, r);
    send(16'h4000, 16, 1'b0, r);
    send(16'h4000, 16, 1'b0, r);
    send(16'hC000, 16, 1'b0, r);
    chk("unarmed fire reply", squib_cmd_pkg::RESP_SEQ, r);
    chk("arm pulses", 16'h0001, arm_seen);
    chk("fire pulses", 16'h0001, fire_seen);
    chk("low side", {8'h00, 8'hF7}, {8'h00, ls_seen});
    $display("test deploy finished");
  endtask : t_deploy
  task automatic t_errors;
    logic [15:0] r;
    logic [15:0] a;
    a = arm_seen;
    send(16'h5900, 16, 1'b1, r);
    send(16'hC000, 16, 1'b0, r);
    chk("parity reply", squib_cmd_pkg::RESP_PARITY, r);
    send(16'h5900, 15, 1'b0, r);
    send(16'hC000, 16, 1'b0, r);
    chk("count reply", squib_cmd_pkg::RESP_COUNT, r);
    chk("arm pulses", a, arm_seen);
    tick();
    deploy_active = 1'b1;
    send(16'h5900, 16, 1'b0, r);
    send(16'h8602, 16, 1'b0, r);
    chk("busy arm reply", squib_cmd_pkg::RESP_BUSY, r);
    send(16'hC000, 16, 1'b0, r);
    chk("busy reply", squib_cmd_pkg::RESP_BUSY, r);
    chk("arm pulses", a, arm_seen);
    send(16'hC000, 16, 1'b0, r);
    chk("monitor echo", {6'h00, monitor_data[9:0]}, {6'h00, r[9:0]});
    tick();
    deploy_active = 1'b0;
    $display("test errors finished");
  endtask : t_errors
  task automatic t_diag;
    logic [15:0] r;
    logic [1:0]  lv [3] = '{2'h0, 2'h1, 2'h3};
    for (int i = 0; i < 6; i++) begin
      tick();
      comp = (i < 3) ? {i > 0, i > 1, 2'b00} : {2'b00, i > 3, i > 4};
      repeat (3) send((i < 3) ? 16'h8602 : 16'h8405, 16, 1'b0, r);
      chk("diag result", {14'h0000, lv[i % 3]}, {14'h0000, r[1:0]});
      chk("diag select", {13'h0000, (i < 3) ? 3'h3 : 3'h2}, {13'h0000, diag_select});
      chk("diag channel", {13'h0000, (i < 3) ? 3'h2 : 3'h5}, {13'h0000, diag_channel});
      chk("test current", {15'h0000, i < 3}, {15'h0000, safing_test_current});
    end
    // low-side diagnostic reports the fault input on the frame after next
    tick();
    ls_fault = 1'b1;
    repeat (3) send(16'h8C03, 16, 1'b0, r);
    chk("ls diag fault", 16'h0001, {14'h0000, r[1:0]});
    chk("diag select", 16'h0006, {13'h0000, diag_select});
    tick();
    ls_fault = 1'b0;
    $display("test diag finished");
  endtask : t_diag
  task automatic t_config;
    logic [15:0] r;
    send(16'h1300, 16, 1'b0, r);
    send(16'h18AA, 16, 1'b0, r);
    chk("current select", 16'h0003, {14'h0000, firing_current_select});
    send(16'h1855, 16, 1'b0, r);
    chk("first key reply", squib_cmd_pkg::RESP_SWR1 | 16'h0300, r);
    send(16'hC000, 16, 1'b0, r);
    chk("second key reply", squib_cmd_pkg::RESP_SWR2, r);
    chk("soft resets", 16'h0001, swr_seen);
    chk("current select", 16'h0000, {14'h0000, firing_current_select});
    send(16'h18AA, 16, 1'b0, r);
    send(16'hC000, 16, 1'b0, r);
    send(16'h1855, 16, 1'b0, r);
    send(16'h1600, 16, 1'b0, r);
    chk("soft resets", 16'h0001, swr_seen);
    chk("latch time", 16'h0002, {14'h0000, fire_latch_time});
    $display("test config finished");
  endtask : t_config
  task automatic t_pins;
    logic [15:0] r;
    tick();
    reference_resistor = 1'b0;
    send(16'hC000, 16, 1'b0, r);
    send(16'hC000, 16, 1'b0, r);
    chk("resistor reply", 16'h0000, r);
    tick();
    reference_resistor = 1'b1;
    send(16'hC000, 16, 1'b0, r);
    chk("resistor held reply", 16'h0000, r);
    tick();
    reset_pin_low = 1'b0;
    repeat (3) tick();
    reset_pin_low = 1'b1;
    send(16'hC000, 16, 1'b0, r);
    chk("pin reset reply", 16'h0000, r);
    $display("test pins finished");
  endtask : t_pins
  // ---------------------------------------------------------------
  // main sequence and hang guard
  // ---------------------------------------------------------------
  initial begin
    repeat (4) tick();
    rst = 1'b0;
    repeat (4) tick();
    t_deploy();
    t_errors();
    t_diag();
    t_config();
    t_pins();
    complete_run();
  end
  // run needs about 1000 cycles; 4000 means a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_count++;
      complete_run();
    end
  end
endmodule : tb_top
`default_nettype wire
